// ===== plldc_regs.svh
// Register offsets, field positions, reset values and widths of the loop divider block
`ifndef PLLDC_REGS_SVH
`define PLLDC_REGS_SVH

// ---------------------------------------------------------------------------
// Register address space
// ---------------------------------------------------------------------------
`define PLLDC_ADDR_W          10
`define PLLDC_DATA_W          8

`define PLLDC_OFS_PWR_STATE   10'h010
`define PLLDC_OFS_REF_LO      10'h011
`define PLLDC_OFS_REF_HI      10'h012
`define PLLDC_OFS_SWALLOW     10'h013
`define PLLDC_OFS_MAIN_LO     10'h014
`define PLLDC_OFS_MAIN_HI     10'h015
`define PLLDC_OFS_CTRL        10'h016

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PLLDC_RST_PWR_STATE   2'h1
`define PLLDC_RST_REF_LO      8'h01
`define PLLDC_RST_REF_HI      6'h00
`define PLLDC_RST_SWALLOW     6'h00
`define PLLDC_RST_MAIN_LO     8'h03
`define PLLDC_RST_MAIN_HI     5'h00
`define PLLDC_RST_CTRL_BIT    1'h0

// ---------------------------------------------------------------------------
// Field widths and positions
// ---------------------------------------------------------------------------
`define PLLDC_REF_W           14
`define PLLDC_SWALLOW_W       6
`define PLLDC_MAIN_W          13
`define PLLDC_REF_HI_W        6
`define PLLDC_MAIN_HI_W       5
`define PLLDC_PWR_W           2

`define PLLDC_CODE_RUN        2'h0
`define PLLDC_CODE_ASYNC_PD   2'h1
`define PLLDC_CODE_SYNC_PD    2'h3

`define PLLDC_BIT_PUMP_MID    7
`define PLLDC_BIT_HOLD_REF    6
`define PLLDC_BIT_HOLD_FB     5
`define PLLDC_BIT_HOLD_ALL    4
`define PLLDC_BIT_BYPASS_MAIN 3

`endif

// ===== plldc_pkg.sv
// Types shared by the loop divider control block
package plldc_pkg;

  // Decoded loop power state
  typedef enum logic [1:0] {
    PLLDC_PWR_RUN,
    PLLDC_PWR_ASYNC_PD,
    PLLDC_PWR_SYNC_PD,
    PLLDC_PWR_UNUSED
  } plldc_pwr_t;

endpackage : plldc_pkg

// ===== plldc_div_if.sv
// Settings and events passed between register block and divider counters
`timescale 1ns/1ps
`include "plldc_regs.svh"

interface plldc_div_if;
  logic [`PLLDC_REF_W-1:0]     ref_count;
  logic [`PLLDC_SWALLOW_W-1:0] swallow_count;
  logic [`PLLDC_MAIN_W-1:0]    main_count;
  logic                        hold_ref;
  logic                        hold_fb;
  logic                        bypass_main;
  logic                        ref_tick;
  logic                        fb_tick;
  logic                        ref_pulse;
  logic                        fb_pulse;
  logic                        modulus_hi;

  modport ctrl (
    output ref_count, swallow_count, main_count, hold_ref, hold_fb,
    output bypass_main, ref_tick, fb_tick,
    input  ref_pulse, fb_pulse, modulus_hi
  );

  modport div (
    input  ref_count, swallow_count, main_count, hold_ref, hold_fb,
    input  bypass_main, ref_tick, fb_tick,
    output ref_pulse, fb_pulse, modulus_hi
  );
endinterface : plldc_div_if

// ===== plldc_dividers.sv
// Reference, swallow and main feedback counters of the synthesizer loop
`timescale 1ns/1ps
`include "plldc_regs.svh"

module plldc_dividers #(
  parameter int REF_W  = `PLLDC_REF_W,
  parameter int SWAL_W = `PLLDC_SWALLOW_W,
  parameter int MAIN_W = `PLLDC_MAIN_W
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  plldc_div_if.div  div
);

  // Counters must hold every value the registers can carry
  if (REF_W < `PLLDC_REF_W || SWAL_W < `PLLDC_SWALLOW_W ||
      MAIN_W < `PLLDC_MAIN_W) begin : g_width_check
    $error("plldc_dividers: counter narrower than its register field");
  end

  logic [REF_W-1:0]  ref_cnt;
  logic [SWAL_W-1:0] swal_cnt;
  logic [MAIN_W-1:0] main_cnt;
  logic              main_wrap;

  // Terminal count of a down counter; a zero setting divides by one
  function automatic logic at_end(input logic [31:0] cnt);
    return (cnt <= 32'h0000_0001);
  endfunction

  assign main_wrap = div.fb_tick & (div.bypass_main |
                     at_end(32'(main_cnt)));

  // Reference divider, held while its hold is set
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || div.hold_ref) begin
      ref_cnt       <= REF_W'(div.ref_count);
      div.ref_pulse <= 1'b0;
    end else if (div.ref_tick) begin
      div.ref_pulse <= at_end(32'(ref_cnt));
      ref_cnt       <= at_end(32'(ref_cnt)) ? REF_W'(div.ref_count)
                                             : ref_cnt - 1'b1;
    end else begin
      div.ref_pulse <= 1'b0;
    end
  end

  // Main feedback count, bypassed to pass every feedback edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || div.hold_fb) begin
      main_cnt     <= MAIN_W'(div.main_count);
      div.fb_pulse <= 1'b0;
    end else if (div.fb_tick) begin
      div.fb_pulse <= main_wrap;
      main_cnt     <= main_wrap ? MAIN_W'(div.main_count)
                                : main_cnt - 1'b1;
    end else begin
      div.fb_pulse <= 1'b0;
    end
  end

  // Swallow count: high modulus for the first edges of each main cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || div.hold_fb) begin
      swal_cnt       <= SWAL_W'(div.swallow_count);
      div.modulus_hi <= 1'b0;
    end else if (div.fb_tick) begin
      if (main_wrap) begin
        swal_cnt <= SWAL_W'(div.swallow_count);
      end else if (swal_cnt != '0) begin
        swal_cnt <= swal_cnt - 1'b1;
      end
      div.modulus_hi <= main_wrap ? (div.swallow_count != '0)
                                  : (swal_cnt > SWAL_W'(1));
    end
  end

endmodule // plldc_dividers

// ===== plldc_top.sv
// Loop divider and power-state control registers with their counters
`timescale 1ns/1ps
`include "plldc_regs.svh"

module plldc_top (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // Register port from the serial control port
  input  wire logic [`PLLDC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`PLLDC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [`PLLDC_DATA_W-1:0] reg_rdata_o,
  output logic                          reg_rvalid_o,
  // Divider inputs from pins
  input  wire logic                     ref_clk_in_i,
  input  wire logic                     fb_clk_in_i,
  // Loop control outputs
  output logic                          loop_run_o,
  output logic                          async_pd_o,
  output logic                          sync_pd_o,
  output logic                          pump_output_mid_o,
  output logic                          ref_div_pulse_o,
  output logic                          fb_div_pulse_o,
  output logic                          modulus_hi_o
);

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  logic [`PLLDC_PWR_W-1:0]     pwr_code;
  logic [`PLLDC_DATA_W-1:0]    ref_lo;
  logic [`PLLDC_REF_HI_W-1:0]  ref_hi;
  logic [`PLLDC_SWALLOW_W-1:0] swallow;
  logic [`PLLDC_DATA_W-1:0]    main_lo;
  logic [`PLLDC_MAIN_HI_W-1:0] main_hi;
  logic                        pump_mid;
  logic                        hold_ref;
  logic                        hold_fb;
  logic                        hold_all;
  logic                        bypass_main;
  plldc_pkg::plldc_pwr_t       pwr_state;
  logic                        loop_on;
  logic [2:0]                  ref_sync;
  logic [2:0]                  fb_sync;
  logic [`PLLDC_DATA_W-1:0]    next_rdata;

  // Bundle of settings and events towards the counter module
  plldc_div_if div_bus ();

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------

  // Write strobe for one register offset
  // Unmapped offsets never match, so writes to them are dropped
  function automatic logic wr_hit(input logic [`PLLDC_ADDR_W-1:0] ofs);
    return reg_wr_i && (reg_addr_i == ofs);
  endfunction

  // Map the two-bit power field onto the decoded state
  // Code 10 keeps a state of its own so that it can never run the loop
  function automatic plldc_pkg::plldc_pwr_t decode_pwr(
    input logic [`PLLDC_PWR_W-1:0] code
  );
    plldc_pkg::plldc_pwr_t st;
    st = plldc_pkg::PLLDC_PWR_UNUSED;
    if (code == `PLLDC_CODE_RUN) begin
      st = plldc_pkg::PLLDC_PWR_RUN;
    end else if (code == `PLLDC_CODE_ASYNC_PD) begin
      st = plldc_pkg::PLLDC_PWR_ASYNC_PD;
    end else if (code == `PLLDC_CODE_SYNC_PD) begin
      st = plldc_pkg::PLLDC_PWR_SYNC_PD;
    end
    return st;
  endfunction

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------

  // Two stages settle a pin that changes near the clock edge; the third
  // stage only keeps the old level for rising-edge detection, so a pin
  // that idles high gives one edge just after reset, dropped by the held counters
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_sync <= 3'h0;
      fb_sync  <= 3'h0;
    end else begin
      ref_sync <= {ref_sync[1:0], ref_clk_in_i};
      fb_sync  <= {fb_sync[1:0], fb_clk_in_i};
    end
  end

  // -------------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------------

  // Power field, off after reset
  // Code 10 is stored as written and reads back unchanged
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwr_code <= `PLLDC_RST_PWR_STATE;
    end else if (wr_hit(`PLLDC_OFS_PWR_STATE)) begin
      pwr_code <= reg_wdata_i[`PLLDC_PWR_W-1:0];
    end
  end

  // Reference divider bytes
  // Each byte loads on its own; there is no staging of the pair
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_lo <= `PLLDC_RST_REF_LO;
      ref_hi <= `PLLDC_RST_REF_HI;
    end else begin
      if (wr_hit(`PLLDC_OFS_REF_LO)) begin
        ref_lo <= reg_wdata_i;
      end
      if (wr_hit(`PLLDC_OFS_REF_HI)) begin
        ref_hi <= reg_wdata_i[`PLLDC_REF_HI_W-1:0];
      end
    end
  end

  // Swallow count, upper two bits dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      swallow <= `PLLDC_RST_SWALLOW;
    end else if (wr_hit(`PLLDC_OFS_SWALLOW)) begin
      swallow <= reg_wdata_i[`PLLDC_SWALLOW_W-1:0];
    end
  end

  // Main feedback count bytes
  // The counters pick up a new pair at their next reload
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      main_lo <= `PLLDC_RST_MAIN_LO;
      main_hi <= `PLLDC_RST_MAIN_HI;
    end else begin
      if (wr_hit(`PLLDC_OFS_MAIN_LO)) begin
        main_lo <= reg_wdata_i;
      end
      if (wr_hit(`PLLDC_OFS_MAIN_HI)) begin
        main_hi <= reg_wdata_i[`PLLDC_MAIN_HI_W-1:0];
      end
    end
  end

  // Control byte: pump force, counter holds and bypass
  // Bits 2..0 are not stored, so they read back as zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pump_mid    <= `PLLDC_RST_CTRL_BIT;
      hold_ref    <= `PLLDC_RST_CTRL_BIT;
      hold_fb     <= `PLLDC_RST_CTRL_BIT;
      hold_all    <= `PLLDC_RST_CTRL_BIT;
      bypass_main <= `PLLDC_RST_CTRL_BIT;
    end else if (wr_hit(`PLLDC_OFS_CTRL)) begin
      pump_mid    <= reg_wdata_i[`PLLDC_BIT_PUMP_MID];
      hold_ref    <= reg_wdata_i[`PLLDC_BIT_HOLD_REF];
      hold_fb     <= reg_wdata_i[`PLLDC_BIT_HOLD_FB];
      hold_all    <= reg_wdata_i[`PLLDC_BIT_HOLD_ALL];
      bypass_main <= reg_wdata_i[`PLLDC_BIT_BYPASS_MAIN];
    end
  end

  // -------------------------------------------------------------------------
  // Register reads
  // -------------------------------------------------------------------------

  // Read mux; unused bits and unmapped offsets give zero
  // A read in the cycle of a write to the same offset shows the old value
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_i == `PLLDC_OFS_PWR_STATE) begin
      next_rdata[`PLLDC_PWR_W-1:0] = pwr_code;
    end else if (reg_addr_i == `PLLDC_OFS_REF_LO) begin
      next_rdata = ref_lo;
    end else if (reg_addr_i == `PLLDC_OFS_REF_HI) begin
      next_rdata[`PLLDC_REF_HI_W-1:0] = ref_hi;
    end else if (reg_addr_i == `PLLDC_OFS_SWALLOW) begin
      next_rdata[`PLLDC_SWALLOW_W-1:0] = swallow;
    end else if (reg_addr_i == `PLLDC_OFS_MAIN_LO) begin
      next_rdata = main_lo;
    end else if (reg_addr_i == `PLLDC_OFS_MAIN_HI) begin
      next_rdata[`PLLDC_MAIN_HI_W-1:0] = main_hi;
    end else if (reg_addr_i == `PLLDC_OFS_CTRL) begin
      next_rdata[`PLLDC_BIT_PUMP_MID]    = pump_mid;
      next_rdata[`PLLDC_BIT_HOLD_REF]    = hold_ref;
      next_rdata[`PLLDC_BIT_HOLD_FB]     = hold_fb;
      next_rdata[`PLLDC_BIT_HOLD_ALL]    = hold_all;
      next_rdata[`PLLDC_BIT_BYPASS_MAIN] = bypass_main;
    end
  end

  // Read data registered, one cycle after the strobe
  // Data stays after the valid pulse until the next read
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Power state
  // -------------------------------------------------------------------------

  // Only the run code lets the loop operate
  assign pwr_state = decode_pwr(pwr_code);
  assign loop_on   = (pwr_state == plldc_pkg::PLLDC_PWR_RUN);

  // Power outputs from flops
  // Both power-down codes stop the counters at once; sync_pd_o only
  // tells the analog side which kind of shutdown was asked for
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      loop_run_o <= 1'b0;
      async_pd_o <= 1'b1;
      sync_pd_o  <= 1'b0;
    end else begin
      loop_run_o <= loop_on;
      async_pd_o <= (pwr_state == plldc_pkg::PLLDC_PWR_ASYNC_PD);
      sync_pd_o  <= (pwr_state == plldc_pkg::PLLDC_PWR_SYNC_PD);
    end
  end

  // Pump force to half supply
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pump_output_mid_o <= 1'b0;
    end else begin
      pump_output_mid_o <= pump_mid;
    end
  end

  // -------------------------------------------------------------------------
  // Divider counters
  // -------------------------------------------------------------------------

  // Settings and holds; a stopped loop keeps every counter held
  // Writing the bytes of a pair one by one may give one period at a
  // mixed ratio; set a hold bit around the update to avoid it
  assign div_bus.ref_count     = {ref_hi, ref_lo};
  assign div_bus.swallow_count = swallow;
  assign div_bus.main_count    = {main_hi, main_lo};
  assign div_bus.hold_ref      = hold_ref | hold_all | ~loop_on;
  assign div_bus.hold_fb       = hold_fb | hold_all | ~loop_on;
  assign div_bus.bypass_main   = bypass_main;
  assign div_bus.ref_tick      = ref_sync[1] & ~ref_sync[2];
  assign div_bus.fb_tick       = fb_sync[1] & ~fb_sync[2];

  // Counters run on the synchronised pin edges only
  plldc_dividers u_dividers (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .div        (div_bus.div)
  );

  // -------------------------------------------------------------------------
  // Divider event outputs
  // -------------------------------------------------------------------------

  // Reference event retimed so the pin leaves a flop of this module
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_div_pulse_o <= 1'b0;
    end else begin
      ref_div_pulse_o <= div_bus.ref_pulse;
    end
  end

  // Feedback events; one cycle later than the counters, same count
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fb_div_pulse_o <= 1'b0;
      modulus_hi_o   <= 1'b0;
    end else begin
      fb_div_pulse_o <= div_bus.fb_pulse;
      modulus_hi_o   <= div_bus.modulus_hi;
    end
  end

endmodule // plldc_top

// ===== plldc_top_sva.sv
// Port-level checks of the loop divider control register block
`timescale 1ns/1ps
`include "plldc_regs.svh"

module plldc_top_sva (
  input wire logic                     core_clk_i,
  input wire logic                     rst_n_i,
  input wire logic [`PLLDC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`PLLDC_DATA_W-1:0] reg_wdata_i,
  input wire logic                     reg_wr_i,
  input wire logic                     reg_rd_i,
  input wire logic [`PLLDC_DATA_W-1:0] reg_rdata_o,
  input wire logic                     reg_rvalid_o,
  input wire logic                     ref_clk_in_i,
  input wire logic                     fb_clk_in_i,
  input wire logic                     loop_run_o,
  input wire logic                     async_pd_o,
  input wire logic                     sync_pd_o,
  input wire logic                     pump_output_mid_o,
  input wire logic                     ref_div_pulse_o,
  input wire logic                     fb_div_pulse_o,
  input wire logic                     modulus_hi_o
);
  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  logic [7:0] ctrl_sh;
  wire        wr_ctrl = reg_wr_i && reg_addr_i == `PLLDC_OFS_CTRL;
  wire        wr_pwr  = reg_wr_i && reg_addr_i == `PLLDC_OFS_PWR_STATE;
  wire        rd_none = reg_rd_i && (reg_addr_i < `PLLDC_OFS_PWR_STATE ||
                                     reg_addr_i > `PLLDC_OFS_CTRL);

  // Shadow of the counter control byte
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      ctrl_sh <= 8'h00;
    else if (wr_ctrl)
      ctrl_sh <= reg_wdata_i;
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_reset_outputs: assert property (
    $rose(rst_n_i) |-> async_pd_o && !loop_run_o && !sync_pd_o &&
                       !pump_output_mid_o && !reg_rvalid_o)
    else $error("outputs wrong at reset release");
  chk_rd_answer: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered in one cycle");
  chk_rvalid_cause: assert property (
    reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  chk_unmapped_zero: assert property (
    rd_none |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_pwr_decode: assert property (
    wr_pwr ##1 !wr_pwr [*2] |-> {loop_run_o, async_pd_o, sync_pd_o} ==
      (($past(reg_wdata_i[1:0], 2) == 2'h0) ? 3'b100 :
       ($past(reg_wdata_i[1:0], 2) == 2'h1) ? 3'b010 :
       ($past(reg_wdata_i[1:0], 2) == 2'h3) ? 3'b001 : 3'b000))
    else $error("power outputs do not follow code");
  chk_pump_follow: assert property (
    wr_ctrl ##1 !wr_ctrl [*2] |->
      pump_output_mid_o == $past(reg_wdata_i[7], 2))
    else $error("pump output does not follow bit 7");
  chk_idle_quiet: assert property (
    !loop_run_o [*3] |-> !ref_div_pulse_o && !fb_div_pulse_o)
    else $error("divider pulse while loop stopped");
  chk_hold_ref: assert property (
    (ctrl_sh[6] || ctrl_sh[4]) [*3] |-> !ref_div_pulse_o)
    else $error("reference pulse while held");
  chk_hold_fb: assert property (
    (ctrl_sh[5] || ctrl_sh[4]) [*3] |-> !fb_div_pulse_o)
    else $error("feedback pulse while held");
endmodule // plldc_top_sva

// ===== plldc_top_test.sv
// Self-checking bench for the loop divider control registers
`timescale 1ns/1ps
`include "plldc_regs.svh"

module plldc_top_test;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       ref_clk_in_i = 1'b0;
  logic       fb_clk_in_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       reg_rvalid_o, loop_run_o, async_pd_o, sync_pd_o;
  logic       pump_output_mid_o, ref_div_pulse_o, fb_div_pulse_o;
  logic       modulus_hi_o;
  logic [7:0] shadow [0:1023];
  logic [7:0] exp_q [$];
  int         n_fail, checked, ref_cnt, fb_cnt, mod_cnt;
  logic       mod_prev = 1'b0;

  plldc_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .ref_clk_in_i(ref_clk_in_i),
    .fb_clk_in_i(fb_clk_in_i), .loop_run_o(loop_run_o),
    .async_pd_o(async_pd_o), .sync_pd_o(sync_pd_o),
    .pump_output_mid_o(pump_output_mid_o),
    .ref_div_pulse_o(ref_div_pulse_o), .fb_div_pulse_o(fb_div_pulse_o),
    .modulus_hi_o(modulus_hi_o));

  // 20 MHz clock
  always #25 core_clk_i = ~core_clk_i;

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  function automatic logic [7:0] fmask(input logic [9:0] a);
    case (a)
      `PLLDC_OFS_PWR_STATE: fmask = 8'h03;
      `PLLDC_OFS_REF_LO, `PLLDC_OFS_MAIN_LO: fmask = 8'hFF;
      `PLLDC_OFS_REF_HI, `PLLDC_OFS_SWALLOW: fmask = 8'h3F;
      `PLLDC_OFS_MAIN_HI: fmask = 8'h1F;
      `PLLDC_OFS_CTRL: fmask = 8'hF8;
      default: fmask = 8'h00;
    endcase
  endfunction

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    check("reads_left", 8'(exp_q.size()), 8'h00);
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One write strobe for one cycle, shadow keeps the expected contents
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_i = 1'b1;
    reg_rd_i = 1'b0;
    reg_addr_i = a;
    reg_wdata_i = d;
    shadow[a] = d & fmask(a);
  endtask

  task automatic rd(input logic [9:0] a);
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    exp_q.push_back(shadow[a]);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
    end
  endtask

  // Restart counters, apply control byte, count pulses over n pin edges
  task automatic divrun(input logic [7:0] c, input int n, input int er,
                        input int ef, input int em);
    int r0, f0, m0;
    wr(`PLLDC_OFS_CTRL, 8'h10);
    wr(`PLLDC_OFS_CTRL, c);
    idle(3);
    r0 = ref_cnt;
    f0 = fb_cnt;
    m0 = mod_cnt;
    repeat (n) begin
      ref_clk_in_i = 1'b1;
      fb_clk_in_i = 1'b1;
      idle(3);
      ref_clk_in_i = 1'b0;
      fb_clk_in_i = 1'b0;
      idle(3);
    end
    idle(8);
    check("ref_pulses", 8'(ref_cnt - r0), 8'(er));
    check("fb_pulses", 8'(fb_cnt - f0), 8'(ef));
    check("mod_rises", 8'(mod_cnt - m0), 8'(em));
  endtask

  // ---------------------------------------------------------------------
  // Result watchers
  // ---------------------------------------------------------------------
  // Pair each read answer with the oldest expected value
  always @(negedge core_clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0)
        check("rvalid_extra", 8'h01, 8'h00);
      else
        check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
    end
    if (ref_div_pulse_o === 1'b1)
      ref_cnt++;
    if (fb_div_pulse_o === 1'b1)
      fb_cnt++;
    if (modulus_hi_o === 1'b1 && mod_prev !== 1'b1)
      mod_cnt++;
    mod_prev = modulus_hi_o;
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (6000) @(posedge core_clk_i);
    n_fail++;
    end_sim();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    int i;
    int unsigned v;
    v = $urandom(38);
    foreach (shadow[k])
      shadow[k] = 8'h00;
    shadow[`PLLDC_OFS_PWR_STATE] = 8'h01;
    shadow[`PLLDC_OFS_REF_LO] = 8'h01;
    shadow[`PLLDC_OFS_MAIN_LO] = 8'h03;
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    // Reset outputs and back to back reads of offsets 0x0F to 0x17 and 0x3FF
    check("async_pd_o", {7'h0, async_pd_o}, 8'h01);
    check("pump_mid", {7'h0, pump_output_mid_o}, 8'h00);
    for (i = 15; i <= 23; i++)
      rd(10'(i));
    rd(10'h3FF);
    idle(3);
    // Random and all-ones data, unused bits must read zero
    for (i = 15; i <= 23; i++) begin
      v = $urandom;
      wr(10'(i), 8'(v));
      rd(10'(i));
      wr(10'(i), 8'hFF);
      rd(10'(i));
    end
    idle(3);
    // Every power code
    for (i = 0; i < 4; i++) begin
      wr(`PLLDC_OFS_PWR_STATE, 8'(i));
      idle(3);
      check("loop_run_o", {7'h0, loop_run_o}, {7'h0, i == 0});
      check("async_pd_o", {7'h0, async_pd_o}, {7'h0, i == 1});
      check("sync_pd_o", {7'h0, sync_pd_o}, {7'h0, i == 3});
    end
    // Pump forced to mid supply and back
    wr(`PLLDC_OFS_CTRL, 8'h80);
    idle(3);
    check("pump_mid", {7'h0, pump_output_mid_o}, 8'h01);
    wr(`PLLDC_OFS_CTRL, 8'h00);
    idle(3);
    check("pump_mid", {7'h0, pump_output_mid_o}, 8'h00);
    // Dividers: reference 3, swallow 0, main 2
    wr(`PLLDC_OFS_PWR_STATE, 8'h00);
    wr(`PLLDC_OFS_REF_LO, 8'h03);
    wr(`PLLDC_OFS_REF_HI, 8'h00);
    wr(`PLLDC_OFS_SWALLOW, 8'h00);
    wr(`PLLDC_OFS_MAIN_LO, 8'h02);
    wr(`PLLDC_OFS_MAIN_HI, 8'h00);
    divrun(8'h00, 12, 4, 6, 0);
    divrun(8'h40, 12, 0, 6, 0);
    divrun(8'h20, 12, 4, 0, 0);
    divrun(8'h10, 12, 0, 0, 0);
    divrun(8'h08, 12, 4, 12, 0);
    // Swallow of one: high modulus once per main cycle, then no pulses once powered down
    wr(`PLLDC_OFS_SWALLOW, 8'h01);
    divrun(8'h00, 12, 4, 6, 6);
    wr(`PLLDC_OFS_PWR_STATE, 8'h01);
    divrun(8'h00, 12, 0, 0, 0);
    end_sim();
  end
endmodule // plldc_top_test

bind plldc_top plldc_top_sva u_sva (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .ref_clk_in_i(ref_clk_in_i),
  .fb_clk_in_i(fb_clk_in_i), .loop_run_o(loop_run_o),
  .async_pd_o(async_pd_o), .sync_pd_o(sync_pd_o),
  .pump_output_mid_o(pump_output_mid_o),
  .ref_div_pulse_o(ref_div_pulse_o), .fb_div_pulse_o(fb_div_pulse_o),
  .modulus_hi_o(modulus_hi_o));
